// ---- scsb_baud.v ----
`include "scsb_defs.vh"

// ****************************************
// Prescaler taps and baud divider
// ****************************************
module scsb_baud (
	input  wire       ref_clk,
	input  wire       rst_n,
	input  wire [1:0] tapSel,
	input  wire [3:0] divN,
	input  wire       fracEn,
	input  wire [3:0] fracK,
	input  wire       dblBuf,
	input  wire       uartMode,
	output reg        baudTick
);
	reg  [6:0] pre_ff;
	reg  [4:0] cnt_ff;
	reg  [3:0] acc_ff;
	reg        extra_ff;
	reg        tapTick;
	wire [4:0] nFull;
	wire [4:0] nUse;
	wire [4:0] target;
	wire [4:0] accSum;

	// Tap pulses at 1/2, 1/8, 1/32, 1/128 of the clock
	always @*
	begin
		case (tapSel)
			2'h0:    tapTick = pre_ff[0];
			2'h1:    tapTick = &pre_ff[2:0];
			2'h2:    tapTick = &pre_ff[4:0];
			2'h3:    tapTick = &pre_ff[6:0];
			default: tapTick = 1'b0;
		endcase
	end

	// Zero stands for 16; divide-by-1 only behind a double buffer
	assign nFull  = (divN == 4'h0) ? 5'h10 : {1'b0, divN};
	assign nUse   = (nFull < `SCSB_N_MIN_SGL && !dblBuf) ? `SCSB_N_MIN_SGL : nFull;
	assign target = nUse + {4'h0, extra_ff};
	assign accSum = {1'b0, acc_ff} + (5'h10 - {1'b0, fracK});

	// Divider; fractional part stretches some periods by one tap
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pre_ff   <= 7'h00;
			cnt_ff   <= 5'h00;
			acc_ff   <= 4'h0;
			extra_ff <= 1'b0;
			baudTick <= 1'b0;
		end
		else
		begin
			pre_ff   <= pre_ff + 7'h01;
			baudTick <= 1'b0;
			if (tapTick)
			begin
				if (cnt_ff >= target - 5'h01)
				begin
					cnt_ff   <= 5'h00;
					baudTick <= 1'b1;
					if (uartMode && fracEn && fracK != 4'h0)
					begin
						acc_ff   <= accSum[3:0];
						extra_ff <= accSum[4];
					end
					else
					begin
						acc_ff   <= 4'h0;
						extra_ff <= 1'b0;
					end
				end
				else
					cnt_ff <= cnt_ff + 5'h01;
			end
		end
	end
endmodule

// ---- scsb_defs.vh ----
`ifndef SCSB_DEFS_VH
`define SCSB_DEFS_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define SCSB_A_MODE0     8'h00
`define SCSB_A_CHAN      8'h04
`define SCSB_A_MODE1     8'h08
`define SCSB_A_MODE2     8'h0C
`define SCSB_A_BAUD      8'h10
`define SCSB_A_FRAC      8'h14
`define SCSB_A_FCFG      8'h18
`define SCSB_A_DATA      8'h1C
`define SCSB_A_STAT      8'h20

// ****************************************
// Field codes
// ****************************************
`define SCSB_MODE_IO     2'h0
`define SCSB_MODE_UART   2'h1
`define SCSB_UC_TIMER    2'h0
`define SCSB_UC_BAUD     2'h1
`define SCSB_UC_FSYS     2'h2
`define SCSB_UC_SCLK     2'h3
`define SCSB_DPX_RX      2'h1
`define SCSB_DPX_TX      2'h2
`define SCSB_DPX_FULL    2'h3

// ****************************************
// Counts
// ****************************************
`define SCSB_FIFO_ALL    6'h04
`define SCSB_FIFO_HALF   6'h02
`define SCSB_OVS_LAST    4'hF
`define SCSB_OVS_MID     4'h7
`define SCSB_UART_BITS   4'hA
`define SCSB_IO_BITS     4'h8
`define SCSB_N_MIN_SGL   5'h02

`endif

// ---- scsb_fifo.v ----
// ****************************************
// Buffer FIFO with a run-time usable depth
// ****************************************
module scsb_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	input  wire             ref_clk,
	input  wire             rst_n,
	input  wire             clear,
	input  wire [AW:0]      limit,
	input  wire             inValid,
	output wire             inReady,
	input  wire [WIDTH-1:0] inData,
	output wire             outValid,
	input  wire             outReady,
	output wire [WIDTH-1:0] outData,
	output wire [AW:0]      count
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wrPtr_ff;
	reg [AW-1:0]    rdPtr_ff;
	reg [AW:0]      cnt_ff;
	wire            push;
	wire            pop;

	// Full is reached at the usable depth, not the array size
	assign inReady  = (cnt_ff < limit) && (cnt_ff < DEPTH);
	assign outValid = (cnt_ff != {(AW+1){1'b0}});
	assign push     = inValid & inReady;
	assign pop      = outValid & outReady;
	assign outData  = mem[rdPtr_ff];
	assign count    = cnt_ff;

	// Storage array
	always @(posedge ref_clk)
	begin
		if (push)
			mem[wrPtr_ff] <= inData;
	end

	// Pointers and fill count
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wrPtr_ff <= {AW{1'b0}};
			rdPtr_ff <= {AW{1'b0}};
			cnt_ff   <= {(AW+1){1'b0}};
		end
		else if (clear)
		begin
			wrPtr_ff <= {AW{1'b0}};
			rdPtr_ff <= {AW{1'b0}};
			cnt_ff   <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wrPtr_ff <= wrPtr_ff + {{(AW-1){1'b0}}, 1'b1};
			if (pop)
				rdPtr_ff <= rdPtr_ff + {{(AW-1){1'b0}}, 1'b1};
			if (push && !pop)
				cnt_ff <= cnt_ff + {{AW{1'b0}}, 1'b1};
			else if (pop && !push)
				cnt_ff <= cnt_ff - {{AW{1'b0}}, 1'b1};
		end
	end
endmodule

// ---- scsb_serial_clk_buf.v ----
// Overview of operation
// - The mode field picks I/O or UART; I/O clocking follows the channel control bits, UART clocking its own source field.
// - With the shift clock driven out, data is driven on the falling edge and sampled on the rising edge, and the clock is half the baud tick rate.
// - With the shift clock taken in, shifting happens on the rising or falling edge as the edge bit selects.
// - A baud divide ratio of 1 is honoured only with double buffering, otherwise 2 is used.
// - UART mode clocks from the timer output, the baud generator, the system clock or the clock pin.
// - In UART mode each bit spans 16 pulses of the chosen clock in both receive and transmit counters.
// - The transmit side is single buffered when the buffer bit is clear and double when set.
// - Receive is double buffered in UART and external-clock I/O modes, else it follows the buffer bit.
// - The 4-byte FIFO works only when both the double-buffer bit and the FIFO enable bit are set.
// - Duplex 01 gives 4 receive bytes, 10 gives 4 transmit bytes, 11 gives 2 bytes each.
// - The baud input is one of four prescaler taps dividing by 2, 8, 32 or 128.
// - UART may divide by N plus (16-K)/16; I/O mode divides by an integer N only.
//
// Our own choices: the register addresses and strobed register access.
`include "scsb_defs.vh"

module scsb_serial_clk_buf #(
	parameter FIFO_DEPTH = 32,
	parameter FIFO_AW    = 5
) (
	input  wire        ref_clk,
	input  wire        rst_n,
	input  wire [7:0]  regAddr,
	input  wire [31:0] regWrData,
	input  wire        regWrStb,
	input  wire        regRdStb,
	output reg  [31:0] regRdData,
	input  wire        rxd,
	output reg         txd,
	input  wire        timerOut,
	input  wire        sclkIn,
	output reg         sclkOut,
	output wire        sclkOe_n
);
	// ****************************************
	// Declarations
	// ****************************************
	reg  [1:0]  smode_ff, ucSrc_ff, tap_ff, fdpx_ff;
	reg         ioc_ff, edge_ff, wbuf_ff, fracEn_ff, fifoEn_ff;
	reg  [3:0]  brs_ff, fracK_ff;
	reg         sclkS1, sclkS2, sclkS3, rxdS1, rxdS2, tmrS1, tmrS2, tmrS3;
	reg  [7:0]  txBuf_ff, rxBuf_ff, rxPendData_ff, rxShift_ff;
	reg         txBufFull_ff, rxBufFull_ff, rxPend_ff, overrun_ff;
	reg  [9:0]  txShift_ff;
	reg  [3:0]  txBits_ff, txCnt_ff, rxCnt_ff, rxBits_ff;
	reg         txBusy_ff, rxActive_ff;
	reg         uartTick, ioDrive, ioSample, rxDone;
	wire        baudTick, uartMode, ioOut, fifoOn, txDbl, rxDbl;
	wire        wrData, rdData, rdStat, txFifoUse, rxFifoUse, txReady, rxAvail;
	wire        txFifoInRdy, txFifoOutVld, rxFifoInRdy, rxFifoOutVld;
	wire [7:0]  txFifoOut, rxFifoOut;
	wire [5:0]  txLimit, rxLimit, txCount, rxCount;
	wire        clrTx, clrRx, sclkRise, sclkFall, tmrRise, ioRun;
	wire        txFromFifo, shiftLoad, rxToFifo, txAccept, rxFree;
	wire [7:0]  shiftSrc;

	// ****************************************
	// Mode decode
	// ****************************************
	assign uartMode = (smode_ff == `SCSB_MODE_UART);
	assign ioOut    = !uartMode && !ioc_ff;
	assign sclkOe_n = !ioOut;
	assign fifoOn   = wbuf_ff & fifoEn_ff;
	assign txDbl    = wbuf_ff;
	assign rxDbl    = uartMode | ioc_ff | wbuf_ff;
	assign txLimit  = !fifoOn ? 6'h00 : (fdpx_ff == `SCSB_DPX_TX) ? `SCSB_FIFO_ALL :
		(fdpx_ff == `SCSB_DPX_FULL) ? `SCSB_FIFO_HALF : 6'h00;
	assign rxLimit  = !fifoOn ? 6'h00 : (fdpx_ff == `SCSB_DPX_RX) ? `SCSB_FIFO_ALL :
		(fdpx_ff == `SCSB_DPX_FULL) ? `SCSB_FIFO_HALF : 6'h00;
	assign txFifoUse = (txLimit != 6'h00);
	assign rxFifoUse = (rxLimit != 6'h00);

	// Register strobes; FIFO clears are write-one pulses
	assign wrData = regWrStb && (regAddr == `SCSB_A_DATA);
	assign rdData = regRdStb && (regAddr == `SCSB_A_DATA);
	assign rdStat = regRdStb && (regAddr == `SCSB_A_STAT);
	assign clrTx  = regWrStb && (regAddr == `SCSB_A_FCFG) && regWrData[1];
	assign clrRx  = regWrStb && (regAddr == `SCSB_A_FCFG) && regWrData[2];

	// ****************************************
	// Pin synchronisers and edge detect
	// ****************************************
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			{sclkS1, sclkS2, sclkS3} <= 3'h7;
			{rxdS1, rxdS2}           <= 2'h3;
			{tmrS1, tmrS2, tmrS3}    <= 3'h0;
		end
		else
		begin
			{sclkS1, sclkS2, sclkS3} <= {sclkIn, sclkS1, sclkS2};
			{rxdS1, rxdS2}           <= {rxd, rxdS1};
			{tmrS1, tmrS2, tmrS3}    <= {timerOut, tmrS1, tmrS2};
		end
	end
	assign sclkRise = sclkS2 & !sclkS3;
	assign sclkFall = !sclkS2 & sclkS3;
	assign tmrRise  = tmrS2 & !tmrS3;

	// ****************************************
	// Baud generator and FIFOs
	// ****************************************
	scsb_baud uBaud (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.tapSel   (tap_ff),
		.divN     (brs_ff),
		.fracEn   (fracEn_ff),
		.fracK    (fracK_ff),
		.dblBuf   (wbuf_ff),
		.uartMode (uartMode),
		.baudTick (baudTick)
	);

	scsb_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) uTxFifo (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.clear    (clrTx),
		.limit    (txLimit),
		.inValid  (wrData & txFifoUse),
		.inReady  (txFifoInRdy),
		.inData   (regWrData[7:0]),
		.outValid (txFifoOutVld),
		.outReady (!txBufFull_ff),
		.outData  (txFifoOut),
		.count    (txCount)
	);

	scsb_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) uRxFifo (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.clear    (clrRx),
		.limit    (rxLimit),
		.inValid  (rxBufFull_ff & rxFifoUse),
		.inReady  (rxFifoInRdy),
		.inData   (rxBuf_ff),
		.outValid (rxFifoOutVld),
		.outReady (rdData & rxFifoUse),
		.outData  (rxFifoOut),
		.count    (rxCount)
	);

	// ****************************************
	// Transfer clock selection
	// ****************************************
	// Output clock runs only with a frame loaded and somewhere to put the reply
	assign ioRun = ioOut && txBusy_ff && !rxPend_ff && (rxDbl || !rxBufFull_ff);

	always @*
	begin
		case (ucSrc_ff)
			`SCSB_UC_TIMER: uartTick = tmrRise;
			`SCSB_UC_BAUD:  uartTick = baudTick;
			`SCSB_UC_FSYS:  uartTick = 1'b1;
			`SCSB_UC_SCLK:  uartTick = sclkRise;
			default:        uartTick = 1'b0;
		endcase
		if (ioOut)
		begin
			ioSample = ioRun && baudTick && !sclkOut;
			ioDrive  = ioRun && baudTick && sclkOut;
		end
		else
		begin
			ioSample = edge_ff ? sclkFall : sclkRise;
			ioDrive  = edge_ff ? sclkRise : sclkFall;
		end
	end

	// Shift clock out: idle high, toggles on every baud tick
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			sclkOut <= 1'b1;
		else if (!ioRun)
			sclkOut <= 1'b1;
		else if (baudTick)
			sclkOut <= !sclkOut;
	end

	// ****************************************
	// Transmit path
	// ****************************************
	assign txReady    = txFifoUse ? txFifoInRdy : (txDbl ? !txBufFull_ff : !txBusy_ff);
	assign txAccept   = wrData && txReady;
	assign txFromFifo = txFifoUse && txFifoOutVld && !txBufFull_ff;
	assign shiftLoad  = !txBusy_ff && (txBufFull_ff || (txAccept && !txDbl));
	assign shiftSrc   = txBufFull_ff ? txBuf_ff : regWrData[7:0];

	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			txBuf_ff     <= 8'h00;
			txBufFull_ff <= 1'b0;
			txShift_ff   <= 10'h3FF;
			txBits_ff    <= 4'h0;
			txCnt_ff     <= 4'h0;
			txBusy_ff    <= 1'b0;
			txd          <= 1'b1;
		end
		else
		begin
			// Hold stage fed by the FIFO or by a direct write
			if (txFromFifo)
			begin
				txBuf_ff     <= txFifoOut;
				txBufFull_ff <= 1'b1;
			end
			else if (txAccept && txDbl && !txFifoUse)
			begin
				txBuf_ff     <= regWrData[7:0];
				txBufFull_ff <= 1'b1;
			end
			else if (shiftLoad && txBufFull_ff)
				txBufFull_ff <= 1'b0;
			if (shiftLoad)
			begin
				txBusy_ff  <= 1'b1;
				txCnt_ff   <= 4'h0;
				txShift_ff <= uartMode ? {1'b1, shiftSrc, 1'b0} : {2'h3, shiftSrc};
				txBits_ff  <= uartMode ? `SCSB_UART_BITS : `SCSB_IO_BITS;
			end
			else if (txBusy_ff && uartMode && uartTick)
			begin
				txCnt_ff <= txCnt_ff + 4'h1;
				if (txCnt_ff == `SCSB_OVS_LAST)
				begin
					if (txBits_ff != 4'h0)
					begin
						txd        <= txShift_ff[0];
						txShift_ff <= {1'b1, txShift_ff[9:1]};
						txBits_ff  <= txBits_ff - 4'h1;
					end
					else
						txBusy_ff <= 1'b0;
				end
			end
			else if (txBusy_ff && !uartMode)
			begin
				if (ioDrive && txBits_ff != 4'h0)
				begin
					txd        <= txShift_ff[0];
					txShift_ff <= {1'b1, txShift_ff[9:1]};
					txBits_ff  <= txBits_ff - 4'h1;
				end
				if (rxDone)
					txBusy_ff <= 1'b0;
			end
		end
	end

	// ****************************************
	// Receive shifting
	// ****************************************
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rxShift_ff  <= 8'h00;
			rxCnt_ff    <= 4'h0;
			rxBits_ff   <= 4'h0;
			rxActive_ff <= 1'b0;
			rxDone      <= 1'b0;
		end
		else
		begin
			rxDone <= 1'b0;
			if (!uartMode)
			begin
				rxActive_ff <= 1'b0;
				if (ioSample)
				begin
					rxShift_ff <= {rxdS2, rxShift_ff[7:1]};
					rxBits_ff  <= (rxBits_ff == 4'h7) ? 4'h0 : rxBits_ff + 4'h1;
					rxDone     <= (rxBits_ff == 4'h7);
				end
			end
			else if (!rxActive_ff)
			begin
				rxCnt_ff  <= 4'h0;
				rxBits_ff <= 4'h0;
				if (!rxdS2)
					rxActive_ff <= 1'b1;
			end
			else if (uartTick)
			begin
				rxCnt_ff <= rxCnt_ff + 4'h1;
				if (rxCnt_ff == `SCSB_OVS_MID)
				begin
					rxBits_ff <= rxBits_ff + 4'h1;
					if (rxBits_ff == 4'h0 && rxdS2)
						rxActive_ff <= 1'b0;
					else if (rxBits_ff == `SCSB_UART_BITS - 4'h1)
					begin
						rxActive_ff <= 1'b0;
						rxDone      <= 1'b1;
					end
					else if (rxBits_ff != 4'h0)
						rxShift_ff <= {rxdS2, rxShift_ff[7:1]};
				end
			end
		end
	end

	// ****************************************
	// Receive buffering
	// ****************************************
	assign rxToFifo = rxBufFull_ff && rxFifoUse && rxFifoInRdy;
	assign rxAvail  = rxFifoUse ? rxFifoOutVld : rxBufFull_ff;
	assign rxFree   = rxToFifo || (rdData && !rxFifoUse && rxBufFull_ff);

	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rxBuf_ff      <= 8'h00;
			rxBufFull_ff  <= 1'b0;
			rxPendData_ff <= 8'h00;
			rxPend_ff     <= 1'b0;
			overrun_ff    <= 1'b0;
		end
		else
		begin
			// Buffer frees on a read or a move into the FIFO; a pending byte refills it
			if (rxFree)
			begin
				rxBufFull_ff <= rxPend_ff;
				rxBuf_ff     <= rxPendData_ff;
				rxPend_ff    <= 1'b0;
			end
			if (rxDone)
			begin
				// A byte landing as the buffer frees must not strand the pending slot
				if (!rxBufFull_ff || (rxFree && !rxPend_ff))
				begin
					rxBuf_ff     <= rxShift_ff;
					rxBufFull_ff <= 1'b1;
				end
				else if (!rxPend_ff || rxFree)
				begin
					rxPendData_ff <= rxShift_ff;
					rxPend_ff     <= 1'b1;
				end
			end
			// Set wins over the clear-on-read
			if (rxDone && rxBufFull_ff && rxPend_ff && !rxFree)
				overrun_ff <= 1'b1;
			else if (rdStat)
				overrun_ff <= 1'b0;
		end
	end

	// ****************************************
	// Register writes
	// ****************************************
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			smode_ff  <= `SCSB_MODE_IO;
			ucSrc_ff  <= `SCSB_UC_TIMER;
			ioc_ff    <= 1'b0;
			edge_ff   <= 1'b0;
			fdpx_ff   <= 2'h0;
			wbuf_ff   <= 1'b0;
			brs_ff    <= 4'h0;
			tap_ff    <= 2'h0;
			fracEn_ff <= 1'b0;
			fracK_ff  <= 4'h0;
			fifoEn_ff <= 1'b0;
		end
		else if (regWrStb)
		begin
			case (regAddr)
				`SCSB_A_MODE0: {ucSrc_ff, smode_ff} <= regWrData[3:0];
				`SCSB_A_CHAN:  {edge_ff, ioc_ff} <= regWrData[1:0];
				`SCSB_A_MODE1: fdpx_ff <= regWrData[1:0];
				`SCSB_A_MODE2: wbuf_ff <= regWrData[0];
				`SCSB_A_BAUD:  {fracEn_ff, tap_ff, brs_ff} <= regWrData[6:0];
				`SCSB_A_FRAC:  fracK_ff <= regWrData[3:0];
				`SCSB_A_FCFG:  fifoEn_ff <= regWrData[0];
				default:       fifoEn_ff <= fifoEn_ff;
			endcase
		end
	end

	// ****************************************
	// Register reads, one cycle after the strobe
	// ****************************************
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			regRdData <= 32'h0000_0000;
		else if (regRdStb)
		begin
			case (regAddr)
				`SCSB_A_MODE0: regRdData <= {28'h000_0000, ucSrc_ff, smode_ff};
				`SCSB_A_CHAN:  regRdData <= {30'h0000_0000, edge_ff, ioc_ff};
				`SCSB_A_MODE1: regRdData <= {30'h0000_0000, fdpx_ff};
				`SCSB_A_MODE2: regRdData <= {31'h0000_0000, wbuf_ff};
				`SCSB_A_BAUD:  regRdData <= {25'h000_0000, fracEn_ff, tap_ff, brs_ff};
				`SCSB_A_FRAC:  regRdData <= {28'h000_0000, fracK_ff};
				`SCSB_A_FCFG:  regRdData <= {31'h0000_0000, fifoEn_ff};
				`SCSB_A_DATA:  regRdData <= {24'h00_0000, rxFifoUse ? rxFifoOut : rxBuf_ff};
				`SCSB_A_STAT:  regRdData <= {10'h000, rxCount, 2'h0, txCount, 1'b0,
					rxPend_ff, txBufFull_ff, rxBufFull_ff, overrun_ff, txBusy_ff,
					rxAvail, txReady};
				default:       regRdData <= 32'h0000_0000;
			endcase
		end
		else
			regRdData <= 32'h0000_0000;
	end
endmodule

// ---- scsb_serial_clk_buf_asserts.sv ----
`include "scsb_defs.vh"

module scsb_serial_clk_buf_asserts #(
	parameter FIFO_DEPTH = 32,
	parameter FIFO_AW    = 5
) (
	input wire        ref_clk,
	input wire        rst_n,
	input wire [7:0]  regAddr,
	input wire [31:0] regWrData,
	input wire        regWrStb,
	input wire        regRdStb,
	input wire [31:0] regRdData,
	input wire        txd,
	input wire        sclkOut,
	input wire        sclkOe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Shadow of the clocking fields
	// ****************************************
	logic [3:0] mode0_ff;
	logic       ioc_ff;
	logic       dbl_ff;
	logic       ioOut;
	// Follow writes to mode, channel and buffer registers
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode0_ff <= 4'h0;
			ioc_ff   <= 1'b0;
			dbl_ff   <= 1'b0;
		end
		else if (regWrStb)
		begin
			if (regAddr == `SCSB_A_MODE0)
				mode0_ff <= regWrData[3:0];
			if (regAddr == `SCSB_A_CHAN)
				ioc_ff <= regWrData[0];
			if (regAddr == `SCSB_A_MODE2)
				dbl_ff <= regWrData[0];
		end
	end
	// Shift clock driven out in I/O mode
	assign ioOut = (mode0_ff[1:0] == `SCSB_MODE_IO) && !ioc_ff;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// One UART bit at fsys: 15 quiet cycles after each edge
	sequence s_bitHold;
		$stable(txd)[*8] ##1 $stable(txd)[*7];
	endsequence

	a_rd_idle_zero: assert property (!$past(regRdStb) |-> regRdData == 32'h0000_0000)
		else $error("read data not zero outside read cycle");
	a_rd_upper_zero: assert property ($past(regRdStb) |-> regRdData[31:22] == 10'h000)
		else $error("upper read bits not zero");
	a_unmapped_zero: assert property ($past(regRdStb) && $past(regAddr) > `SCSB_A_STAT
		|-> regRdData == 32'h0000_0000) else $error("unmapped read not zero");
	a_fifo_clr_pulse: assert property ($past(regRdStb) && $past(regAddr) == `SCSB_A_FCFG
		|-> regRdData[2:1] == 2'h0) else $error("fifo clear bits read back");
	a_oe_follows_mode: assert property (sclkOe_n == !ioOut)
		else $error("clock enable does not follow mode");
	a_uart_bit_len: assert property (mode0_ff == {`SCSB_UC_FSYS, `SCSB_MODE_UART}
		&& $changed(txd) |=> s_bitHold) else $error("uart bit shorter than 16 clocks");
	a_sclk_single_min: assert property (ioOut && !dbl_ff && $changed(sclkOut)
		|=> $stable(sclkOut)[*3]) else $error("single buffer shift clock too fast");
	a_sclk_double_min: assert property (ioOut && dbl_ff && $changed(sclkOut)
		|=> $stable(sclkOut)) else $error("double buffer shift clock too fast");
endmodule

bind scsb_serial_clk_buf scsb_serial_clk_buf_asserts #(
	.FIFO_DEPTH(FIFO_DEPTH),
	.FIFO_AW(FIFO_AW)
) scsb_serial_clk_buf_asserts_i (
	.ref_clk(ref_clk),
	.rst_n(rst_n),
	.regAddr(regAddr),
	.regWrData(regWrData),
	.regWrStb(regWrStb),
	.regRdStb(regRdStb),
	.regRdData(regRdData),
	.txd(txd),
	.sclkOut(sclkOut),
	.sclkOe_n(sclkOe_n)
);

// ---- scsb_serial_peer.sv ----
module scsb_serial_peer (
	input  wire  ref_clk,
	output logic rxd,
	input  wire  txd,
	output logic timerOut,
	output logic sclkIn
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       tmrOn    = 1'b0;
	logic       sclkFree = 1'b0;
	logic       xferClk  = 1'b1;
	logic [1:0] freeCnt  = 2'h0;
	// ****************************************
	// Far-side serial device
	// ****************************************
	// Idle line high, timer parked so a timer clock stalls, clock pin still
	initial
	begin
		rxd = 1'b1;
	end
	// Free count: bit 0 is a timer toggling on every match, bit 1 a pin clock of 4 fsys
	always @(posedge ref_clk)
		freeCnt <= freeCnt + 2'h1;
	assign timerOut = tmrOn & freeCnt[0];
	assign sclkIn   = sclkFree ? freeCnt[1] : xferClk;
	// Start or park the free-running UART clocks
	task run_free(input logic t, input logic s);
		tmrOn    <= t;
		sclkFree <= s;
	endtask
	// Send start, 8 data bits LSB first, stop; bt clocks a bit
	task send(input int bt, input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		@(posedge ref_clk);
		for (int i = 0; i < 10; i++)
		begin
			rxd <= fr[i];
			repeat (bt) @(posedge ref_clk);
		end
	endtask
	// Capture 8 data bits and stop bit at mid-bit
	task recv(input int bt, output logic [8:0] f);
		wait (txd === 1'b0);
		repeat (bt / 2) @(posedge ref_clk);
		for (int i = 0; i < 9; i++)
		begin
			repeat (bt) @(posedge ref_clk);
			f[i] = txd;
		end
	endtask
	// I/O byte on the clock pin: falls first, 10 fsys a period, txd taken at the rise
	task xfer(input logic [7:0] b, output logic [7:0] got);
		@(posedge ref_clk);
		for (int i = 0; i < 8; i++)
		begin
			rxd     <= b[i];
			xferClk <= 1'b0;
			repeat (5) @(posedge ref_clk);
			xferClk <= 1'b1;
			got[i] = txd;
			repeat (5) @(posedge ref_clk);
		end
		rxd <= 1'b1;
	endtask
endmodule

// ---- tb.sv ----
`include "scsb_defs.vh"

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Bench signals and counters
	// ****************************************
	logic        ref_clk;
	logic        rst_n;
	logic [7:0]  regAddr;
	logic [31:0] regWrData;
	logic        regWrStb;
	logic        regRdStb;
	wire  [31:0] regRdData;
	wire         rxd;
	wire         txd;
	wire         timerOut;
	wire         sclkIn;
	wire         sclkOut;
	wire         sclkOe_n;
	int          num_errors;
	int          total_checks;
	int          cycles;
	int          n;
	logic [31:0] d;
	logic [8:0]  f;

	scsb_serial_clk_buf scsb_serial_clk_buf_i (
		.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
		.regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .rxd(rxd),
		.txd(txd), .timerOut(timerOut), .sclkIn(sclkIn), .sclkOut(sclkOut),
		.sclkOe_n(sclkOe_n));
	scsb_serial_peer scsb_serial_peer_i (
		.ref_clk(ref_clk), .rxd(rxd), .txd(txd), .timerOut(timerOut), .sclkIn(sclkIn));

	// 50 MHz clock
	always #10 ref_clk = ~ref_clk;
	// Hang guard
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			num_errors++;
			results();
		end
	end
	// ****************************************
	// Bus tasks and comparison
	// ****************************************
	task do_reset;
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		regAddr   <= a;
		regWrData <= v;
		regWrStb  <= 1'b1;
		@(posedge ref_clk);
		regWrStb  <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge ref_clk);
		regAddr  <= a;
		regRdStb <= 1'b1;
		@(posedge ref_clk);
		regRdStb <= 1'b0;
		@(negedge ref_clk);
		v = regRdData;
	endtask
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask
	task results;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ****************************************
	// Test sequence
	// ****************************************
	initial
	begin
		ref_clk = 1'b0;
		rst_n = 1'b0;
		regAddr = 8'h00;
		regWrData = 32'h0000_0000;
		regWrStb = 1'b0;
		regRdStb = 1'b0;
		do_reset();
		// Reset state: config zero, unmapped zero, clock pin driven
		chk("sclkOe_n", 32'h0000_0000, sclkOe_n);
		for (int a = 0; a <= 'h24; a += 4)
			if (a != 'h1C && a != 'h20)
			begin
				rd(a[7:0], d);
				chk("regReset", 32'h0000_0000, d);
			end
		wr(`SCSB_A_MODE2, 32'hFFFF_FFFF);
		rd(`SCSB_A_MODE2, d);
		chk("bufBit", 32'h0000_0001, d);
		// UART on fsys, timer and clock pin: frame out, then one byte in
		for (int s = 0; s < 3; s++)
		begin
			do_reset();
			scsb_serial_peer_i.run_free(s == 1, s == 2);
			n = (s == 0) ? 2 : (s == 1) ? 0 : 3;
			wr(`SCSB_A_MODE0, n * 4 + 1);
			@(negedge ref_clk);
			chk("sclkOe_n", 32'h0000_0001, sclkOe_n);
			wr(`SCSB_A_DATA, 32'h0000_01A5);
			scsb_serial_peer_i.recv(16 << s, f);
			chk("txFrame", 32'h0000_01A5, f);
			scsb_serial_peer_i.send(16 << s, 8'h3C);
			rd(`SCSB_A_STAT, d);
			chk("rxAvail", 32'h0000_0001, d[1]);
			rd(`SCSB_A_DATA, d);
			chk("rxByte", 32'h0000_003C, d);
		end
		scsb_serial_peer_i.run_free(1'b0, 1'b0);
		// Shift clock taken in: rising edge samples, then falling edge samples
		for (int e = 0; e < 2; e++)
		begin
			do_reset();
			wr(`SCSB_A_CHAN, e * 2 + 1);
			wr(`SCSB_A_DATA, 32'h0000_00C3);
			scsb_serial_peer_i.xfer(8'h96, f[7:0]);
			if (e == 0)
				chk("ioTx", 32'h0000_00C3, f[7:0]);
			rd(`SCSB_A_DATA, d);
			chk("ioRx", 32'h0000_0096, d);
		end
		// FIFO split per duplex code, last pass without double buffer
		for (int i = 0; i < 5; i++)
		begin
			do_reset();
			wr(`SCSB_A_MODE0, 32'h0000_0001);
			wr(`SCSB_A_MODE2, i != 4);
			wr(`SCSB_A_MODE1, (i == 4) ? 2 : i);
			wr(`SCSB_A_FCFG, 32'h0000_0007);
			for (int k = 0; k < 6; k++)
				wr(`SCSB_A_DATA, k);
			rd(`SCSB_A_STAT, d);
			chk("txFifo", (i == 2) ? 4 : (i == 3) ? 2 : 0, d[13:8]);
		end
		// Shift clock out with divide 1: honoured only with double buffer
		for (int b = 0; b < 2; b++)
		begin
			do_reset();
			wr(`SCSB_A_MODE2, b);
			wr(`SCSB_A_BAUD, 32'h0000_0001);
			wr(`SCSB_A_DATA, 32'h0000_0055);
			@(negedge sclkOut);
			n = 0;
			@(negedge ref_clk);
			while (sclkOut === 1'b0)
			begin
				n++;
				@(negedge ref_clk);
			end
			chk("sclkHalf", b ? 2 : 4, n);
		end
		results();
	end
endmodule
